/* hw/vrcp_pkg.sv */
// Package of constants and types for the voice recorder command port.
`default_nettype none
package vrcp_pkg;
	// Fixed upper bits of the 7-bit slave address.
	localparam logic [4:0] SLAVE_HI = 5'h10;
	// Command bytes.
	localparam logic [7:0] OP_PWRUP = 8'h80;
	localparam logic [7:0] OP_ERASE = 8'hD1;
	localparam logic [7:0] OP_ESTOP = 8'hC0;
	localparam logic [7:0] OP_WRITE = 8'hC9;
	localparam logic [7:0] OP_READ  = 8'hE1;
	localparam logic [7:0] OP_CFG   = 8'hB8;
	// Erase is page aligned: the low five address bits are dropped.
	localparam logic [7:0]  PAGE_MASK = 8'hE0;
	localparam logic [15:0] PAGE_STEP = 16'h0020;
	// Fields of the first configuration word.
	localparam int COMP_BIT = 7;
	localparam int AXG_LSB  = 11;
	localparam logic [15:0] CFG_RST = 16'h0000;
	// Status byte layout.
	localparam int ST_READY = 7;
	localparam int ST_INT   = 6;
	localparam int ST_ERASE = 5;
	localparam int ST_PWR   = 4;
	// Timing at the core clock.
	localparam int CLK_NS      = 100;
	localparam int ROW_LOW_NS  = 250;
	localparam int ROW_LOW_CYC = (ROW_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int PAGE_MS     = 256;
	localparam int PAGE_CYC    = PAGE_MS * 1000000 / CLK_NS;
	// A byte handed from the bus side to the core.
	typedef enum logic {K_WBYTE, K_RBYTE} vrcp_kind_t;
	typedef struct packed {
		vrcp_kind_t  kind;
		logic [1:0]  idx;
		logic [7:0]  data;
	} vrcp_req_t;
endpackage
`default_nettype wire

/* hw/vrcp_top.sv */
// Serial command port of the voice recorder with erase sequencing.
`default_nettype none
module vrcp_top #(
	parameter int PAGE_CYC = vrcp_pkg::PAGE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        link_clk_i,
	input  wire logic        link_rst_b_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	input  wire logic        address_strap_low_i,
	input  wire logic        address_strap_high_i,
	input  wire logic        playback_i,
	input  wire logic        record_i,
	input  wire logic        agc_request_i,
	input  wire logic        end_of_message_flag_i,
	input  wire logic        overflow_flag_i,
	input  wire logic [7:0]  mem_rdata_i,
	output var  logic        scl_o,
	output var  logic        scl_oe_o,
	output var  logic        sda_o,
	output var  logic        sda_oe_o,
	output var  logic        row_boundary_pulse_o,
	output var  logic        int_b_o,
	output var  logic        powered_o,
	output var  logic [1:0]  aux_gain_o,
	output var  logic        attenuate_o,
	output var  logic        boost_o,
	output var  logic        agc_enable_o,
	output var  logic [15:0] mem_addr_o,
	output var  logic [7:0]  mem_wdata_o,
	output var  logic        mem_wr_o,
	output var  logic        mem_rd_o
);
	typedef enum logic [2:0] {
		L_IDLE, L_ADDR, L_ACK, L_RX, L_WAIT, L_TX, L_MACK
	} vrcp_lst_t;
	typedef enum logic [1:0] {C_IDLE, C_PAGE, C_LOW} vrcp_cst_t;

	vrcp_lst_t          lst;
	vrcp_cst_t          cst;
	vrcp_pkg::vrcp_req_t req;
	logic [1:0]  scl_s, sda_s, a0_s, a1_s, ack_s, rq_s;
	logic        scl_q, sda_q, rq_q;
	logic [3:0]  bitn;
	logic [7:0]  shreg, reply, opcode, hi, stat;
	logic        rw, req_tgl, ack_tgl, rd_mode, stop_pend;
	logic [1:0]  idx;
	logic [15:0] cfg;
	logic [31:0] cnt;
	logic        scl_r, scl_f, start, stop, new_req, wb, rb;
	logic        wr_data, rd_data, set_addr, er_go, er_stop, int_clr;
	logic        comp;
	logic [1:0]  cfg_gain;

	// Bus pins and straps cross into the link domain through two stages.
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_b_i) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			a0_s  <= 2'h0;
			a1_s  <= 2'h0;
			ack_s <= 2'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], scl_i};
			sda_s <= {sda_s[0], sda_i};
			a0_s  <= {a0_s[0], address_strap_low_i};
			a1_s  <= {a1_s[0], address_strap_high_i};
			ack_s <= {ack_s[0], ack_tgl};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end

	// Edges of the bus lines and the start and stop conditions.
	assign scl_r = scl_s[1] & ~scl_q;
	assign scl_f = ~scl_s[1] & scl_q;
	assign start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
	assign stop  = scl_s[1] & scl_q & ~sda_q & sda_s[1];

	// Open-drain lines only ever pull low.
	always_ff @(posedge link_clk_i) begin
		scl_o <= 1'b0;
		sda_o <= 1'b0;
	end

	// Bus slave: takes bytes, acks them and stretches the clock meanwhile.
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_b_i) begin
			lst      <= L_IDLE;
			bitn     <= 4'h0;
			shreg    <= 8'h00;
			rw       <= 1'b0;
			idx      <= 2'h0;
			req      <= '0;
			req_tgl  <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (stop) begin
			lst      <= L_IDLE;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (start) begin
			lst      <= L_ADDR;
			bitn     <= 4'h0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			case (lst)
				L_ADDR: begin
					if (scl_r) begin
						shreg <= {shreg[6:0], sda_s[1]};
						bitn  <= bitn + 4'h1;
					end else if (scl_f && bitn == 4'h8) begin
						if (shreg[7:1] == {vrcp_pkg::SLAVE_HI, a1_s[1],
							a0_s[1]}) begin
							sda_oe_o <= 1'b1;
							rw       <= shreg[0];
							lst      <= L_ACK;
							idx      <= shreg[0] ? 2'h1 : 2'h0;
							if (shreg[0]) begin
								req     <= {vrcp_pkg::K_RBYTE, 2'h0, 8'h00};
								req_tgl <= ~req_tgl;
							end
						end else begin
							lst <= L_IDLE;
						end
					end
				end
				L_ACK: begin
					if (scl_f) begin
						sda_oe_o <= 1'b0;
						bitn     <= 4'h0;
						scl_oe_o <= rw;
						lst      <= rw ? L_WAIT : L_RX;
					end
				end
				L_RX: begin
					if (scl_r) begin
						shreg <= {shreg[6:0], sda_s[1]};
						bitn  <= bitn + 4'h1;
					end else if (scl_f && bitn == 4'h8) begin
						req      <= {vrcp_pkg::K_WBYTE, idx, shreg};
						req_tgl  <= ~req_tgl;
						idx      <= (idx == 2'h3) ? idx : idx + 2'h1;
						scl_oe_o <= 1'b1;
						lst      <= L_WAIT;
					end
				end
				L_WAIT: begin
					if (ack_s[1] == req_tgl) begin
						scl_oe_o <= 1'b0;
						if (rw) begin
							shreg    <= reply;
							sda_oe_o <= ~reply[7];
							bitn     <= 4'h0;
							lst      <= L_TX;
						end else begin
							sda_oe_o <= 1'b1;
							lst      <= L_ACK;
						end
					end
				end
				L_TX: begin
					if (scl_f) begin
						if (bitn == 4'h7) begin
							sda_oe_o <= 1'b0;
							lst      <= L_MACK;
						end else begin
							shreg    <= {shreg[6:0], 1'b0};
							sda_oe_o <= ~shreg[6];
							bitn     <= bitn + 4'h1;
						end
					end
				end
				L_MACK: begin
					if (scl_r) begin
						if (sda_s[1]) begin
							lst <= L_IDLE;
						end else begin
							req     <= {vrcp_pkg::K_RBYTE, idx, 8'h00};
							req_tgl <= ~req_tgl;
							idx     <= (idx == 2'h3) ? idx : idx + 2'h1;
						end
					end else if (scl_f) begin
						scl_oe_o <= 1'b1;
						lst      <= L_WAIT;
					end
				end
				default: begin
					lst <= L_IDLE;
				end
			endcase
		end
	end

	// Request toggle crosses into the core; the byte is stable by then.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rq_s <= 2'h0;
			rq_q <= 1'b0;
		end else begin
			rq_s <= {rq_s[0], req_tgl};
			rq_q <= rq_s[1];
		end
	end

	// Decoded effects of one handed-over byte.
	assign new_req  = rq_s[1] ^ rq_q;
	assign wb       = new_req && req.kind == vrcp_pkg::K_WBYTE;
	assign rb       = new_req && req.kind == vrcp_pkg::K_RBYTE;
	assign wr_data  = wb && req.idx == 2'h3 && opcode == vrcp_pkg::OP_WRITE;
	assign rd_data  = rb && rd_mode;
	assign set_addr = wb && req.idx == 2'h2 &&
		(opcode == vrcp_pkg::OP_WRITE || opcode == vrcp_pkg::OP_READ);
	assign er_go    = wb && req.idx == 2'h2 && opcode == vrcp_pkg::OP_ERASE;
	assign er_stop  = wb && req.idx == 2'h0 &&
		req.data == vrcp_pkg::OP_ESTOP;
	assign int_clr  = rb && !rd_mode && req.idx == 2'h0;
	assign comp     = cfg[vrcp_pkg::COMP_BIT];
	assign cfg_gain = cfg[vrcp_pkg::AXG_LSB +: 2];

	// Status byte as shown on a status read.
	always_comb begin
		stat                   = 8'h00;
		stat[vrcp_pkg::ST_READY] = (cst == C_IDLE);
		stat[vrcp_pkg::ST_INT]   = ~int_b_o;
		stat[vrcp_pkg::ST_ERASE] = (cst != C_IDLE);
		stat[vrcp_pkg::ST_PWR]   = powered_o;
	end

	// Command bytes, configuration and the answer to each byte.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			opcode    <= 8'h00;
			hi        <= 8'h00;
			cfg       <= vrcp_pkg::CFG_RST;
			rd_mode   <= 1'b0;
			powered_o <= 1'b0;
			reply     <= 8'h00;
			ack_tgl   <= 1'b0;
		end else if (new_req) begin
			ack_tgl <= ~ack_tgl;
			if (wb) begin
				case (req.idx)
					2'h0: begin
						opcode  <= req.data;
						rd_mode <= req.data == vrcp_pkg::OP_READ;
						if (req.data == vrcp_pkg::OP_PWRUP) begin
							powered_o <= 1'b1;
						end
					end
					2'h1: hi <= req.data;
					2'h2: begin
						if (opcode == vrcp_pkg::OP_CFG) begin
							cfg <= {hi, req.data};
						end
					end
					default: ;
				endcase
			end else if (rd_mode) begin
				reply <= mem_rdata_i;
			end else begin
				case (req.idx)
					2'h0: reply <= stat;
					2'h1: reply <= mem_addr_o[15:8];
					default: reply <= mem_addr_o[7:0];
				endcase
			end
		end
	end

	// Interrupt: an event in the clearing cycle wins.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			int_b_o <= 1'b1;
		end else if (end_of_message_flag_i || overflow_flag_i) begin
			int_b_o <= 1'b0;
		end else if (int_clr) begin
			int_b_o <= 1'b1;
		end
	end

	// Erase sequencing, memory address and memory strobes.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cst                  <= C_IDLE;
			cnt                  <= 32'h0;
			stop_pend            <= 1'b0;
			row_boundary_pulse_o <= 1'b1;
			mem_addr_o           <= 16'h0000;
			mem_wdata_o          <= 8'h00;
			mem_wr_o             <= 1'b0;
			mem_rd_o             <= 1'b0;
		end else begin
			mem_wr_o <= wr_data;
			mem_rd_o <= rd_data;
			if (wr_data) begin
				mem_wdata_o <= req.data;
			end
			if (er_stop) begin
				stop_pend <= 1'b1;
			end
			case (cst)
				C_IDLE: begin
					if (er_go) begin
						mem_addr_o <= {hi, req.data & vrcp_pkg::PAGE_MASK};
						cnt        <= 32'h0;
						stop_pend  <= 1'b0;
						cst        <= C_PAGE;
					end else if (set_addr) begin
						mem_addr_o <= {hi, req.data};
					end else if (mem_wr_o || mem_rd_o) begin
						mem_addr_o <= mem_addr_o + 16'h0001;
					end
				end
				C_PAGE: begin
					if (cnt == 32'(PAGE_CYC - 1)) begin
						cnt                  <= 32'h0;
						row_boundary_pulse_o <= 1'b0;
						cst                  <= C_LOW;
					end else begin
						cnt <= cnt + 32'h1;
					end
				end
				C_LOW: begin
					if (cnt == 32'(vrcp_pkg::ROW_LOW_CYC - 1)) begin
						cnt                  <= 32'h0;
						row_boundary_pulse_o <= 1'b1;
						if (stop_pend || er_stop) begin
							stop_pend <= 1'b0;
							cst       <= C_IDLE;
						end else begin
							mem_addr_o <= mem_addr_o + vrcp_pkg::PAGE_STEP;
							cst        <= C_PAGE;
						end
					end else begin
						cnt <= cnt + 32'h1;
					end
				end
				default: cst <= C_IDLE;
			endcase
		end
	end

	// Analog path controls.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			aux_gain_o   <= 2'h0;
			attenuate_o  <= 1'b0;
			boost_o      <= 1'b0;
			agc_enable_o <= 1'b0;
		end else begin
			aux_gain_o   <= cfg_gain;
			attenuate_o  <= playback_i;
			boost_o      <= record_i & comp;
			agc_enable_o <= agc_request_i & ~playback_i &
				~(record_i & comp);
		end
	end

	// Checks on the core side.
	AST_GAIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> aux_gain_o == $past(cfg_gain))
		else $error("aux gain does not follow config");
	AST_ATTEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		playback_i |=> attenuate_o)
		else $error("no attenuation in playback");
	AST_BOOST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> boost_o == ($past(record_i) && $past(comp)))
		else $error("boost wrong for compression bit");
	AST_AGC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(playback_i || (record_i && comp)) |=> !agc_enable_o)
		else $error("agc on with auto gain or mute");
	AST_PWRUP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wb && req.idx == 2'h0 && req.data == vrcp_pkg::OP_PWRUP)
		|=> powered_o)
		else $error("power-up command ignored");
	AST_MASK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(er_go && cst == C_IDLE) |=> mem_addr_o[4:0] == 5'h00 &&
		cst == C_PAGE)
		else $error("erase not page aligned");
	AST_ROWLOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$fell(row_boundary_pulse_o) |-> !row_boundary_pulse_o [*3]
		##1 row_boundary_pulse_o)
		else $error("row pulse width wrong");
	AST_ESTOP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		($rose(row_boundary_pulse_o) && $past(stop_pend)) |-> cst == C_IDLE)
		else $error("erase ran past stop");
	AST_INT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(end_of_message_flag_i || overflow_flag_i) |=> !int_b_o)
		else $error("interrupt not raised");
	// Checks on the link side, then cover points on the core side.
	AST_STRETCH: assert property (@(posedge link_clk_i)
		disable iff (!link_rst_b_i) lst == L_WAIT |-> scl_oe_o)
		else $error("clock not held while waiting");
	AST_IDLE: assert property (@(posedge link_clk_i)
		disable iff (!link_rst_b_i) lst == L_IDLE |-> !sda_oe_o && !scl_oe_o)
		else $error("bus driven while idle");
	COV_ERASE: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(row_boundary_pulse_o) && cst == C_IDLE);
	COV_STATUS: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		int_clr && !int_b_o);
	COV_PWRUP: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(powered_o));
endmodule
`default_nettype wire

/* test/vrcp_host.sv */
// Behavioural bus master that stands in for the host processor.
`default_nettype none
module vrcp_host (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic scl_low_o,
	output var  logic sda_low_o,
	output var  logic hung_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int q = 250; // Quarter bit time; raise it for a slow host.
	// Both lines start released; a stuck clock is flagged.
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
		hung_o = 1'b0;
	end
	// Releases the clock and waits until the wire is really high.
	task automatic rise();
		int n;
		scl_low_o = 1'b0;
		n = 0;
		while (scl_i !== 1'b1 && n < 5000) begin
			#10;
			n++;
		end
		if (n >= 5000) hung_o = 1'b1;
		#(q);
	endtask
	// One bit period: data set while the clock is low, sampled high.
	task automatic cbit(input logic b, output logic s);
		#(q) sda_low_o = ~b;
		#(q);
		rise();
		s = sda_i;
		#(q) scl_low_o = 1'b1;
	endtask
	// Start condition, also usable as a repeated start.
	task automatic start();
		#(q) sda_low_o = 1'b0;
		rise();
		sda_low_o = 1'b1;
		#(q) scl_low_o = 1'b1;
	endtask
	// Stop condition, leaving both lines released.
	task automatic stop();
		#(q) sda_low_o = 1'b1;
		rise();
		sda_low_o = 1'b0;
		#(q);
	endtask
	// Sends a byte; ack is high when the device acknowledged it.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) cbit(d[i], s);
		cbit(1'b1, s);
		ack = ~s;
	endtask
	// Reads a byte, then acknowledges it, or not on the last one.
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) cbit(1'b1, d[i]);
		cbit(nack, s);
	endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the voice recorder command port.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PAGE = 600;
	localparam int TPUD = 50;
	logic        clk_i = 1'b0, lclk = 1'b0, rst_b = 1'b0;
	logic        pb = 1'b0, rec = 1'b0, agc = 1'b0, end_of_message_flag = 1'b0, ovf = 1'b0;
	logic        s_lo = 1'b0, s_hi = 1'b0, seen_str = 1'b0;
	logic        m_scl, m_sda, hung, row, int_b, pwr, att, boost, agc_en;
	logic        mwr, mrd, scl_oe, sda_oe, scl_d, sda_d;
	logic [1:0]  gain;
	logic [7:0]  rdata, wdata, sa;
	logic [15:0] maddr;
	logic [23:0] wq[$];
	int          err_count = 0, n_compared = 0, nrd = 0, nrows = 0, low_w = 0;
	// Pull-ups: a line is low if the device or the host pulls it down.
	wire logic   scl = (scl_oe ? scl_d : 1'b1) & ~m_scl;
	wire logic   sda = (sda_oe ? sda_d : 1'b1) & ~m_sda;
	// Core clock and an unrelated link sampling clock.
	always #50 clk_i = ~clk_i;
	always #15 lclk = ~lclk;
	// Memory contents are a fixed function of the address.
	assign rdata = mem_f(maddr);
	vrcp_top #(.PAGE_CYC(PAGE)) dut (.clk_i(clk_i), .rst_b_i(rst_b),
		.link_clk_i(lclk), .link_rst_b_i(rst_b), .scl_i(scl), .sda_i(sda),
		.address_strap_low_i(s_lo), .address_strap_high_i(s_hi),
		.playback_i(pb), .record_i(rec), .agc_request_i(agc),
		.end_of_message_flag_i(end_of_message_flag), .overflow_flag_i(ovf),
		.mem_rdata_i(rdata), .scl_o(scl_d), .scl_oe_o(scl_oe),
		.sda_o(sda_d),
		.sda_oe_o(sda_oe), .row_boundary_pulse_o(row), .int_b_o(int_b),
		.powered_o(pwr), .aux_gain_o(gain), .attenuate_o(att),
		.boost_o(boost), .agc_enable_o(agc_en), .mem_addr_o(maddr),
		.mem_wdata_o(wdata), .mem_wr_o(mwr), .mem_rd_o(mrd));
	vrcp_host m (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
		.sda_low_o(m_sda), .hung_o(hung));
	function automatic logic [7:0] mem_f(input logic [15:0] a);
		return a[7:0] ^ {a[14:8], a[15]} ^ 8'h5A;
	endfunction
	// Expected status byte from its four flags.
	function automatic logic [7:0] st_f(input logic r, i, e, p);
		return 8'(r) << vrcp_pkg::ST_READY | 8'(i) << vrcp_pkg::ST_INT
			| 8'(e) << vrcp_pkg::ST_ERASE | 8'(p) << vrcp_pkg::ST_PWR;
	endfunction
	// Random byte that never looks like the read command.
	function automatic logic [7:0] rnd8();
		logic [7:0] v;
		v = 8'($urandom);
		return (v == vrcp_pkg::OP_READ) ? 8'h00 : v;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Waits a bounded time for the row pulse count to reach n.
	task automatic wait_rows(input int n);
		int t;
		t = 0;
		while (nrows < n && t < 4 * PAGE) begin
			tick(1);
			t++;
		end
		if (nrows < n) begin
			err_count++;
			conclude();
		end
	endtask
	// Opens a write: command byte, then the address bytes if n > 1.
	task automatic wr_open(input logic [7:0] c, input logic [15:0] a,
		input int n);
		logic k;
		m.start();
		m.wbyte(sa, k);
		chk(k, 1'b1);
		m.wbyte(c, k);
		chk(k, 1'b1);
		if (n > 1) begin
			m.wbyte(a[15:8], k);
			chk(k, 1'b1);
			m.wbyte(a[7:0], k);
			chk(k, 1'b1);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] a, input int n);
		wr_open(c, a, n);
		m.stop();
	endtask
	// Read transfer of n bytes; compared against e when ce is set.
	task automatic rd(input int n, input logic [23:0] e, input logic ce,
		output logic [7:0] s);
		logic k;
		logic [7:0] d;
		m.start();
		m.wbyte(sa | 8'h01, k);
		chk(k, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i == n - 1, d);
			if (i == 0) s = d;
			if (ce) chk(d, e[23 - 8 * i -: 8]);
		end
		m.stop();
	endtask
	// Records memory strobes, row pulse widths and clock stretching.
	always @(negedge clk_i) begin
		if (mwr === 1'b1) wq.push_back({maddr, wdata});
		if (mrd === 1'b1) nrd++;
		if (scl_oe === 1'b1) seen_str = 1'b1;
		if (row === 1'b0) low_w++;
		else if (low_w != 0) begin
			chk(16'(low_w), 16'(vrcp_pkg::ROW_LOW_CYC));
			nrows++;
			low_w = 0;
		end
	end
	// A stuck bus or an overlong run ends in the closing report.
	always @(posedge hung) begin
		err_count++;
		conclude();
	end
	initial begin
		#5000000;
		err_count++;
		conclude();
	end
	// Main sequence.
	initial begin
		logic [7:0] s;
		logic [7:0] d[4];
		logic [15:0] a, cfg;
		logic k, cb;
		int n0;
		void'($urandom(32'h7AEA3032));
		s_lo = 1'($urandom);
		s_hi = 1'($urandom);
		sa = {vrcp_pkg::SLAVE_HI, s_hi, s_lo, 1'b0};
		tick(10);
		rst_b = 1'b1;
		tick(3);
		chk(16'({row, int_b, pwr, gain, scl_oe, sda_oe, scl_d, sda_d}),
			16'h0180);
		m.start();
		m.wbyte(sa ^ 8'h04, k);
		chk(k, 1'b0);
		m.wbyte(vrcp_pkg::OP_PWRUP, k);
		m.stop();
		tick(TPUD);
		chk(pwr, 1'b0);
		wr(vrcp_pkg::OP_PWRUP, 16'h0000, 1);
		tick(TPUD);
		chk(pwr, 1'b1);
		chk(seen_str, 1'b1);
		rd(3, {st_f(1, 0, 0, 1), 16'h0000}, 1'b1, s);
		for (int j = 0; j < 2; j++) begin
			tick(1);
			end_of_message_flag = (j == 0);
			ovf = (j == 1);
			tick(1);
			end_of_message_flag = 1'b0;
			ovf = 1'b0;
			tick(2);
			chk(int_b, 1'b0);
			rd(1, {st_f(1, 1, 0, 1), 16'h0000}, 1'b1, s);
			tick(3);
			chk(int_b, 1'b1);
		end
		// Upper half: compression on, with every playback and record pair.
		for (int g = 0; g < 8; g++) begin
			cfg = {rnd8(), rnd8()};
			cfg[vrcp_pkg::AXG_LSB +: 2] = 2'(g);
			cfg[vrcp_pkg::COMP_BIT] = (g > 3);
			cb = cfg[vrcp_pkg::COMP_BIT];
			wr(vrcp_pkg::OP_CFG, cfg, 3);
			tick(1);
			{pb, rec, agc} = (g > 3) ? {g[1], g[0], 1'b1} : 3'($urandom);
			tick(3);
			chk(gain, 16'(g % 4));
			chk(att, pb);
			chk(boost, rec & cb);
			chk(agc_en, agc & ~pb & ~(rec & cb));
		end
		a = {rnd8(), rnd8()};
		wr_open(vrcp_pkg::OP_WRITE, a, 3);
		for (int i = 0; i < 4; i++) begin
			d[i] = rnd8();
			m.wbyte(d[i], k);
			chk(k, 1'b1);
		end
		m.stop();
		s = 8'h00;
		for (int i = 0; i < 10 && s[vrcp_pkg::ST_READY] !== 1'b1; i++)
			rd(1, 24'h000000, 1'b0, s);
		chk(s, st_f(1, 0, 0, 1));
		rd(3, {st_f(1, 0, 0, 1), a + 16'h0004}, 1'b1, s);
		chk(16'(wq.size()), 16'h0004);
		for (int i = 0; i < 4; i++) begin
			chk(wq[i][23:8], a + 16'(i));
			chk(wq[i][7:0], d[i]);
		end
		m.q = 400;
		a = {rnd8(), rnd8()};
		n0 = nrd;
		wr_open(vrcp_pkg::OP_READ, a, 3);
		rd(3, {mem_f(a), mem_f(a + 16'h0001), mem_f(a + 16'h0002)},
			1'b1, s);
		chk(16'(nrd - n0), 16'h0003);
		a = {rnd8(), rnd8() | 8'h1F};
		wr(vrcp_pkg::OP_ERASE, a, 3);
		chk(maddr, {a[15:8], a[7:0] & vrcp_pkg::PAGE_MASK});
		wr(vrcp_pkg::OP_ESTOP, 16'h0000, 1);
		wait_rows(1);
		tick(2 * PAGE);
		chk(16'(nrows), 16'h0001);
		n0 = nrows;
		wr(vrcp_pkg::OP_ERASE, a, 3);
		rd(1, {st_f(0, 0, 1, 1), 16'h0000}, 1'b1, s);
		wait_rows(n0 + 2);
		wr(vrcp_pkg::OP_ESTOP, 16'h0000, 1);
		wait_rows(n0 + 3);
		tick(2 * PAGE);
		chk(16'(nrows - n0), 16'h0003);
		rd(1, {st_f(1, 0, 0, 1), 16'h0000}, 1'b1, s);
		conclude();
	end
endmodule
`default_nettype wire
